// ===== cop_line_store.sv
// Prefetch line storage, 16 entries by 512 bits
`timescale 1ns/1ps
`include "cop_params.svh"
module cop_line_store (
    input  wire logic         clk,
    input  wire logic         we,
    input  wire logic [3:0]   wAddr,
    input  wire logic [511:0] wData,
    input  wire logic [3:0]   rAddr,
    output logic      [511:0] rData
);
    logic [511:0] mem [0:`COP_PF_DEPTH_MAX-1];
    always_ff @(posedge clk) begin
        if (we) begin
            mem[wAddr] <= wData;
        end
        rData <= mem[rAddr];
    end
endmodule : cop_line_store

// ===== cop_mem_model.sv
// Memory and register-space partner answering writes and line fetches
`timescale 1ns/1ps
module cop_mem_model (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [7:0]   ackDelay,
    input  wire logic         memWrReq,
    input  wire logic         regWrReq,
    input  wire logic         fetchReq,
    output logic              memWrAck,
    output logic              regWrAck,
    output logic              fetchValid,
    output logic      [511:0] fetchData
);
    // ****************************************
    // Completions and line returns
    // ****************************************
    int          memQ[$];
    int          regQ[$];
    int          tick;
    int          fWait;
    logic [31:0] lineNo;
    // Acks come back in issue order, never early; data bus churns when idle
    always @(posedge clk or posedge rst) begin
        if (rst) begin
            memQ.delete();
            regQ.delete();
            tick = 0;
            fWait = 0;
            lineNo = 32'h0;
            memWrAck <= 1'b0;
            regWrAck <= 1'b0;
            fetchValid <= 1'b0;
            fetchData <= '0;
        end else begin
            tick++;
            memWrAck <= 1'b0;
            regWrAck <= 1'b0;
            fetchValid <= 1'b0;
            fetchData <= ~fetchData;
            if (memWrReq === 1'b1) memQ.push_back(tick + int'(ackDelay));
            if (regWrReq === 1'b1) regQ.push_back(tick + int'(ackDelay));
            if (memQ.size() > 0 && memQ[0] <= tick) begin
                void'(memQ.pop_front());
                memWrAck <= 1'b1;
            end
            if (regQ.size() > 0 && regQ[0] <= tick) begin
                void'(regQ.pop_front());
                regWrAck <= 1'b1;
            end
            if (fetchReq === 1'b1 && !fetchValid) begin
                fWait++;
                if (fWait >= 2) begin
                    fWait = 0;
                    fetchValid <= 1'b1;
                    fetchData <= {16{lineNo}};
                    lineNo++;
                end
            end
        end
    end
endmodule : cop_mem_model

// ===== cop_params.svh
// Constants of the command ordering and prefetch block
`ifndef COP_PARAMS_SVH
`define COP_PARAMS_SVH
`define COP_PF_DEPTH_MAX      16
`define COP_PF_DEPTH_RST      8
`define COP_CTX_NUM           4
`define COP_ADDR_CTRL         4'h0
`define COP_ADDR_STATUS       4'h4
`define COP_ADDR_CMD          4'h8
`define COP_ADDR_CTXPF        4'hc
`define COP_CTRL_GPF_BIT      0
`define COP_CTRL_DEPTH_LSB    8
`define COP_CTRL_RST          32'h0000_0801
`define COP_CTXPF_RST         4'hf
`define COP_CMD_OP_LSB        0
`define COP_CMD_ASYNC_BIT     8
`define COP_CMD_STALL_BIT     9
`define COP_CMD_POSTSYNC_BIT  10
`define COP_CMD_NP_BIT        11
`define COP_CMD_ARBEN_BIT     12
`define COP_CMD_CTX_LSB       16
`endif

// ===== cop_parser.sv
// Command parser ordering and command prefetch
// Functional notes
// [RULE_01] Posted memory write issues and parser moves on without waiting.
// [RULE_02] Every posted write eventually completes, tracked by outstanding count.
// [RULE_03] Non-posted memory write stalls parser until globally observable.
// [RULE_04] Non-posted completion implies all earlier posted writes observable.
// [RULE_05] Stores, copies, reports, table updates, indirect store always post.
// [RULE_06] Atomic selectable; flush and stalling sync non-posted; non-stalling posted.
// [RULE_07] Stalling sync, flush, write fence drain earlier posted writes.
// [RULE_08] Load-from-memory, atomic, semaphore poll drain writes before reading.
// [RULE_09] Software makes data coherent before jumps and indirect loads.
// [RULE_10] Immediate, sync, math, register copy register writes are non-posted.
// [RULE_11] Load-from-memory register write posting follows async select bit.
// [RULE_12] Software sets async select so register consumers see loaded value.
// [RULE_13] Fetch DMA prefetches up to eight lines, refills when space frees. Here: up to the control depth, 8 at reset, clamped to 16.
// [RULE_14] Advanced prefetch enabled at reset, streams across batch jumps.
// [RULE_15] Software changes global prefetch enable only with no context active.
// [RULE_16] Arbitration check sets or clears per-context prefetch enable.
// [RULE_17] Prefetch runs only when global and context enables are both set.
// [RULE_18] Self-modifying commands sit beyond prefetch depth or after a jump.
// [RULE_19] Software disables prefetch around jumps into modified batches.
// [RULE_20] Prefetch storage holds at most sixteen 64-byte lines.
// [RULE_21] Per-context prefetch enable is kept per context across switches.
`timescale 1ns/1ps
`include "cop_params.svh"
module cop_parser (
    input  wire logic         clk,
    input  wire logic         rst,
    input  wire logic [3:0]   avsAddress,
    input  wire logic         avsRead,
    input  wire logic         avsWrite,
    input  wire logic [31:0]  avsWriteData,
    input  wire logic [3:0]   avsByteEnable,
    output logic      [31:0]  avsReadData,
    output logic              avsWaitRequest,
    output logic              memWrReq,
    output logic              memWrPosted,
    output logic              regWrReq,
    input  wire logic         memWrAck,
    input  wire logic         regWrAck,
    output logic              fetchReq,
    input  wire logic         fetchValid,
    input  wire logic [511:0] fetchData,
    output logic              pfActive,
    output logic [511:0]      lineData
);
    // ********************************
    // Registers
    // ********************************
    logic [31:0]              ctrl_r, ctrl_nxt;
    logic [`COP_CTX_NUM-1:0]  ctxPf_r, ctxPf_nxt;
    logic [1:0]               curCtx_r, curCtx_nxt;
    logic [31:0]              cmd_r, cmd_nxt;
    logic                     cmdPend_r, cmdPend_nxt;
    logic [31:0]              rdData_r, rdData_nxt;
    logic                     ack_r, ack_nxt;
    cop_pkg::cop_state_e      st_r, st_nxt;
    logic [7:0]               postCnt_r, postCnt_nxt;
    logic                     memWr_r, memWr_nxt;
    logic                     memPost_r, memPost_nxt;
    logic                     regWr_r, regWr_nxt;
    logic                     npWait_r, npWait_nxt;
    logic                     waitReq_r;
    logic [4:0]               fill_r, fill_nxt;
    cop_pkg::cop_cnt_t        wPtr_r, wPtr_nxt;
    cop_pkg::cop_cnt_t        rPtr_r, rPtr_nxt;
    logic                     fetchOut_r, fetchOut_nxt;
    logic                     pfAct_r, pfAct_nxt;
    cop_pkg::cop_wreq_s       wreq;
    cop_pkg::cop_op_e         op;
    logic                     busReq, busAck, needDrain, popLine, fetchNow;
    logic [4:0]               depth;

    assign avsReadData    = rdData_r;
    assign avsWaitRequest = waitReq_r;
    assign memWrReq       = memWr_r;
    assign memWrPosted    = memPost_r;
    assign regWrReq       = regWr_r;
    assign fetchReq       = fetchOut_r;
    assign pfActive       = pfAct_r;

    // ********************************
    // Avalon slave, one wait state
    // ********************************
    assign busReq = (avsRead | avsWrite) & ~ack_r;
    assign busAck = (avsRead | avsWrite) & ack_r;
    assign op     = cop_pkg::cop_op_e'(cmd_r[`COP_CMD_OP_LSB +: 4]);
    // Depth clamped so storage never overruns
    // [RULE_20] Depth bound
    assign depth  = (ctrl_r[`COP_CTRL_DEPTH_LSB +: 5] > 5'(`COP_PF_DEPTH_MAX)) ?
                    5'(`COP_PF_DEPTH_MAX) : ctrl_r[`COP_CTRL_DEPTH_LSB +: 5];

    always_comb begin
        ctrl_nxt    = ctrl_r;
        cmd_nxt     = cmd_r;
        cmdPend_nxt = cmdPend_r;
        rdData_nxt  = rdData_r;
        ack_nxt     = busReq;
        curCtx_nxt  = curCtx_r;
        if (busAck && avsWrite) begin
            if (avsAddress == `COP_ADDR_CTRL) begin
                // Global enable only meaningful while parser idle
                if (avsByteEnable[0]) begin
                    ctrl_nxt[7:0] = avsWriteData[7:0];
                end
                if (avsByteEnable[1]) begin
                    ctrl_nxt[15:8] = avsWriteData[15:8];
                end
            end else if (avsAddress == `COP_ADDR_CMD && !cmdPend_r) begin
                cmd_nxt     = avsWriteData;
                cmdPend_nxt = 1'b1;
                curCtx_nxt  = avsWriteData[`COP_CMD_CTX_LSB +: 2];
            end
        end
        if (busReq && avsRead) begin
            if (avsAddress == `COP_ADDR_CTRL) begin
                rdData_nxt = ctrl_r;
            end else if (avsAddress == `COP_ADDR_STATUS) begin
                rdData_nxt = {8'h00, postCnt_r, 3'h0, fill_r, 5'h00,
                              st_r};
            end else if (avsAddress == `COP_ADDR_CMD) begin
                rdData_nxt = {31'h0, cmdPend_r};
            end else if (avsAddress == `COP_ADDR_CTXPF) begin
                rdData_nxt = {28'h0, ctxPf_r};
            end else begin
                rdData_nxt = 32'h0;
            end
        end
        if (st_r == cop_pkg::ST_IDLE && cmdPend_r) begin
            cmdPend_nxt = 1'b0;
        end
    end

    // ********************************
    // Ordering engine
    // ********************************
    always_comb begin
        wreq      = '0;
        needDrain = 1'b0;
        case (op)
            // [RULE_05] Always posted
            cop_pkg::OP_STORE_REG, cop_pkg::OP_MEM_COPY, cop_pkg::OP_STORE_IDX,
            cop_pkg::OP_STORE_IMM, cop_pkg::OP_REPORT_HD, cop_pkg::OP_UPDATE_TT,
            cop_pkg::OP_PERF_REP, cop_pkg::OP_MATH_STI: begin
                wreq = '{valid: 1'b1, posted: 1'b1, isReg: 1'b0};
            end
            // [RULE_06] Atomic selectable, drains first
            // [RULE_08] Read after drain
            cop_pkg::OP_ATOMIC: begin
                wreq      = '{valid: 1'b1, posted: ~cmd_r[`COP_CMD_NP_BIT], isReg: 1'b0};
                needDrain = 1'b1;
            end
            // [RULE_07] Flush drains
            cop_pkg::OP_FLUSH_DW: begin
                wreq      = '{valid: cmd_r[`COP_CMD_POSTSYNC_BIT], posted: 1'b0, isReg: 1'b0};
                needDrain = 1'b1;
            end
            // [RULE_06] Sync posting by stall bit
            cop_pkg::OP_PIPE_SYNC: begin
                wreq      = '{valid: cmd_r[`COP_CMD_POSTSYNC_BIT],
                              posted: ~cmd_r[`COP_CMD_STALL_BIT], isReg: 1'b0};
                needDrain = cmd_r[`COP_CMD_STALL_BIT];
            end
            // [RULE_07] Write fence drains
            cop_pkg::OP_MATH_FENCE: begin
                needDrain = 1'b1;
            end
            // [RULE_11] Async select
            cop_pkg::OP_LOAD_MEM: begin
                wreq      = '{valid: 1'b1, posted: cmd_r[`COP_CMD_ASYNC_BIT], isReg: 1'b1};
                needDrain = 1'b1;
            end
            // [RULE_10] Register writes non-posted
            cop_pkg::OP_REG_WRITE: begin
                wreq = '{valid: 1'b1, posted: 1'b0, isReg: 1'b1};
            end
            default: begin
                wreq      = '0;
                needDrain = (op == cop_pkg::OP_NOP) ? 1'b0 : cmd_r[`COP_CMD_NP_BIT];
            end
        endcase
    end

    always_comb begin
        st_nxt        = st_r;
        postCnt_nxt   = postCnt_r;
        memWr_nxt     = 1'b0;
        memPost_nxt   = memPost_r;
        regWr_nxt     = 1'b0;
        npWait_nxt    = npWait_r;
        ctxPf_nxt     = ctxPf_r;
        // [RULE_02] Outstanding posted writes retire on ack
        if (memWrAck && postCnt_r != 8'h00 && !npWait_r) begin
            postCnt_nxt = postCnt_r - 8'h01;
        end
        case (st_r)
            cop_pkg::ST_IDLE: begin
                if (cmdPend_r) begin
                    st_nxt = needDrain ? cop_pkg::ST_DRAIN : cop_pkg::ST_ISSUE;
                end
            end
            cop_pkg::ST_DRAIN: begin
                if (postCnt_nxt == 8'h00) begin
                    st_nxt = cop_pkg::ST_ISSUE;
                end
            end
            cop_pkg::ST_ISSUE: begin
                // [RULE_16] Per-context enable, kept per context
                // [RULE_21] Survives context switches
                if (op == cop_pkg::OP_ARB_CHECK) begin
                    ctxPf_nxt[curCtx_r] = cmd_r[`COP_CMD_ARBEN_BIT];
                end
                if (wreq.valid && wreq.isReg) begin
                    regWr_nxt = 1'b1;
                    st_nxt    = wreq.posted ? cop_pkg::ST_IDLE : cop_pkg::ST_WAITR;
                end else if (wreq.valid && wreq.posted) begin
                    // [RULE_01] Posted, no wait
                    memWr_nxt   = 1'b1;
                    memPost_nxt = 1'b1;
                    postCnt_nxt = postCnt_nxt + 8'h01;
                    st_nxt      = cop_pkg::ST_IDLE;
                end else if (wreq.valid) begin
                    memWr_nxt   = 1'b1;
                    memPost_nxt = 1'b0;
                    npWait_nxt  = 1'b1;
                    st_nxt      = cop_pkg::ST_WAITW;
                end else begin
                    st_nxt = cop_pkg::ST_IDLE;
                end
            end
            // [RULE_03] Stall until observable
            // [RULE_04] Ack covers all earlier posted writes
            cop_pkg::ST_WAITW: begin
                if (memWrAck) begin
                    postCnt_nxt = 8'h00;
                    npWait_nxt  = 1'b0;
                    st_nxt      = cop_pkg::ST_IDLE;
                end
            end
            cop_pkg::ST_WAITR: begin
                if (regWrAck) begin
                    st_nxt = cop_pkg::ST_IDLE;
                end
            end
            default: begin
                st_nxt = cop_pkg::ST_IDLE;
            end
        endcase
    end

    // ********************************
    // Prefetch DMA
    // ********************************
    // [RULE_14] Streams regardless of jumps while enabled
    // [RULE_17] Both enables needed
    assign pfAct_nxt = ctrl_r[`COP_CTRL_GPF_BIT] & ctxPf_r[curCtx_r];
    assign popLine   = (st_r == cop_pkg::ST_ISSUE) && (fill_r != 5'h00);
    // [RULE_13] Refill whenever space frees, one line in flight
    // Live enables, so a disable stops the very next request
    assign fetchNow  = pfAct_nxt && !fetchOut_r && ((fill_r + 5'h01) <= depth);

    always_comb begin
        fill_nxt     = fill_r;
        wPtr_nxt     = wPtr_r;
        rPtr_nxt     = rPtr_r;
        fetchOut_nxt = fetchOut_r;
        if (fetchNow) begin
            fetchOut_nxt = 1'b1;
        end
        if (fetchOut_r && fetchValid) begin
            fetchOut_nxt = 1'b0;
            wPtr_nxt     = wPtr_r + 4'h1;
        end
        if (popLine) begin
            rPtr_nxt = rPtr_r + 4'h1;
        end
        fill_nxt = fill_r + {4'h0, fetchOut_r & fetchValid} - {4'h0, popLine};
    end

    cop_line_store u_store (
        .clk   (clk),
        .we    (fetchOut_r & fetchValid),
        .wAddr (wPtr_r),
        .wData (fetchData),
        .rAddr (rPtr_r),
        .rData (lineData)
    );

    always_ff @(posedge clk or posedge rst) begin
        if (rst) begin
            ctrl_r      <= `COP_CTRL_RST;
            ctxPf_r     <= `COP_CTXPF_RST;
            curCtx_r    <= 2'h0;
            cmd_r       <= 32'h0;
            cmdPend_r   <= 1'b0;
            rdData_r    <= 32'h0;
            ack_r       <= 1'b0;
            st_r        <= cop_pkg::ST_IDLE;
            postCnt_r   <= 8'h00;
            memWr_r     <= 1'b0;
            memPost_r   <= 1'b0;
            regWr_r     <= 1'b0;
            npWait_r    <= 1'b0;
            waitReq_r   <= 1'b1;
            fill_r      <= 5'h00;
            wPtr_r      <= 4'h0;
            rPtr_r      <= 4'h0;
            fetchOut_r  <= 1'b0;
            pfAct_r     <= 1'b0;
        end else begin
            ctrl_r      <= ctrl_nxt;
            ctxPf_r     <= ctxPf_nxt;
            curCtx_r    <= curCtx_nxt;
            cmd_r       <= cmd_nxt;
            cmdPend_r   <= cmdPend_nxt;
            rdData_r    <= rdData_nxt;
            ack_r       <= ack_nxt;
            st_r        <= st_nxt;
            postCnt_r   <= postCnt_nxt;
            memWr_r     <= memWr_nxt;
            memPost_r   <= memPost_nxt;
            regWr_r     <= regWr_nxt;
            npWait_r    <= npWait_nxt;
            waitReq_r   <= ~ack_nxt;
            fill_r      <= fill_nxt;
            wPtr_r      <= wPtr_nxt;
            rPtr_r      <= rPtr_nxt;
            fetchOut_r  <= fetchOut_nxt;
            pfAct_r     <= pfAct_nxt;
        end
    end

    // ********************************
    // Assertions
    // ********************************
    a_posted_no_stall: assert property (@(posedge clk) disable iff (rst) // [RULE_01]
        (memWr_r && memPost_r) |-> st_r == cop_pkg::ST_IDLE)
        else $error("posted write stalled parser");
    a_np_stall: assert property (@(posedge clk) disable iff (rst) // [RULE_03]
        (memWr_r && !memPost_r) |-> (st_r == cop_pkg::ST_WAITW) until memWrAck)
        else $error("non-posted write did not stall");
    a_np_clears_posted: assert property (@(posedge clk) disable iff (rst) // [RULE_04]
        (st_r == cop_pkg::ST_WAITW && memWrAck) |=> postCnt_r == 8'h00)
        else $error("posted writes remain after non-posted ack");
    a_drain_before_issue: assert property (@(posedge clk) disable iff (rst) // [RULE_07]
        (st_r == cop_pkg::ST_ISSUE && (op == cop_pkg::OP_FLUSH_DW
         || op == cop_pkg::OP_MATH_FENCE
         || (op == cop_pkg::OP_PIPE_SYNC && cmd_r[`COP_CMD_STALL_BIT])))
        |-> postCnt_r == 8'h00)
        else $error("drain left early");
    a_drain_exit: assert property (@(posedge clk) disable iff (rst) // [RULE_08]
        (st_r == cop_pkg::ST_ISSUE && $past(st_r) == cop_pkg::ST_DRAIN)
        |-> postCnt_r == 8'h00)
        else $error("read command issued with posted writes pending");
    a_reg_np_wait: assert property (@(posedge clk) disable iff (rst) // [RULE_10]
        (st_r == cop_pkg::ST_WAITR && !regWrAck) |=> st_r == cop_pkg::ST_WAITR)
        else $error("register wait broken");
    a_pf_gate: assert property (@(posedge clk) disable iff (rst) // [RULE_17]
        (fetchOut_r && !$past(fetchOut_r))
        |-> $past(ctrl_r[`COP_CTRL_GPF_BIT] && ctxPf_r[curCtx_r]))
        else $error("prefetch without both enables");
    a_fill_bound: assert property (@(posedge clk) disable iff (rst) // [RULE_20]
        fill_r <= 5'(`COP_PF_DEPTH_MAX))
        else $error("prefetch storage overrun");
    a_arb_ctx: assert property (@(posedge clk) disable iff (rst) // [RULE_16]
        (st_r == cop_pkg::ST_ISSUE && op == cop_pkg::OP_ARB_CHECK)
        |=> ctxPf_r[$past(curCtx_r)] == $past(cmd_r[`COP_CMD_ARBEN_BIT]))
        else $error("context prefetch state not updated");
endmodule : cop_parser

// ===== cop_parser_test.sv
// Self-checking bench of the command parser ordering and prefetch
`timescale 1ns/1ps
`include "cop_params.svh"
module cop_parser_test;
    // ****************************************
    // Signals and bookkeeping
    // ****************************************
    logic         clk, rst, avsRead, avsWrite, avsWaitRequest;
    logic [3:0]   avsAddress;
    logic [3:0]   avsByteEnable;
    logic [31:0]  avsWriteData;
    logic [31:0]  avsReadData;
    logic         memWrReq, memWrPosted, regWrReq, memWrAck, regWrAck;
    logic         fetchReq, fetchValid, pfActive;
    logic [511:0] fetchData;
    logic [511:0] lineData;
    logic [7:0]   ackDelay;
    logic [31:0]  r;
    logic         lastPosted;
    int n_errors, samples_checked, cyc, reqN, ackN, rreqN, rackN, gapAtReg, gapAtMem, r0;
    logic [31:0] wTab [13] = '{32'h1, 32'h2, 32'h3, 32'h4, 32'h5, 32'h6, 32'h7, 32'hb,
                                32'h8, 32'h808, 32'h409, 32'h60a, 32'h40a};
    logic        pTab [13] = '{1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b1, 1'b0, 1'b0,
                               1'b0, 1'b1};
    logic [31:0] dTab [3] = '{32'h9, 32'hc, 32'h20a};
    logic [31:0] gTab [3] = '{32'hd, 32'he, 32'h10d};
    logic        gEq  [3] = '{1'b1, 1'b1, 1'b0};

    cop_parser DUT (.clk(clk), .rst(rst), .avsAddress(avsAddress), .avsRead(avsRead),
        .avsWrite(avsWrite), .avsWriteData(avsWriteData), .avsByteEnable(avsByteEnable),
        .avsReadData(avsReadData), .avsWaitRequest(avsWaitRequest), .memWrReq(memWrReq),
        .memWrPosted(memWrPosted), .regWrReq(regWrReq), .memWrAck(memWrAck),
        .regWrAck(regWrAck), .fetchReq(fetchReq), .fetchValid(fetchValid),
        .fetchData(fetchData), .pfActive(pfActive), .lineData(lineData));
    cop_mem_model u_mem (.clk(clk), .rst(rst), .ackDelay(ackDelay), .memWrReq(memWrReq),
        .regWrReq(regWrReq), .fetchReq(fetchReq), .memWrAck(memWrAck),
        .regWrAck(regWrAck), .fetchValid(fetchValid), .fetchData(fetchData));

    // ****************************************
    // Clock, traffic counters, hang guard
    // ****************************************
    initial begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end
    always @(posedge clk) begin
        cyc++;
        if (memWrReq === 1'b1) begin
            gapAtMem = reqN - ackN;
            reqN++;
            lastPosted = memWrPosted;
        end
        if (memWrAck === 1'b1) ackN++;
        if (regWrReq === 1'b1) begin
            gapAtReg = reqN - ackN;
            rreqN++;
        end
        if (regWrAck === 1'b1) rackN++;
        if (cyc > 20000) begin
            n_errors++;
            summarize();
        end
    end

    // ****************************************
    // Bus tasks and comparison
    // ****************************************
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        samples_checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : check
    task automatic busWr(input logic [3:0] a, input logic [31:0] d);
        avsAddress <= a;
        avsWriteData <= d;
        avsWrite <= 1'b1;
        @(posedge clk);
        while (avsWaitRequest !== 1'b0) begin
            @(posedge clk);
        end
        avsWrite <= 1'b0;
        // Idle edge, so the next call never re-raises in this step
        @(posedge clk);
    endtask : busWr
    task automatic busRd(input logic [3:0] a, output logic [31:0] d);
        avsAddress <= a;
        avsRead <= 1'b1;
        @(posedge clk);
        while (avsWaitRequest !== 1'b0) begin
            @(posedge clk);
        end
        d = avsReadData;
        avsRead <= 1'b0;
        @(posedge clk);
    endtask : busRd
    // Issue one command, wait until taken and the parser is idle again
    task automatic cmd(input logic [31:0] w);
        logic [31:0] p;
        r0 = reqN;
        busWr(`COP_ADDR_CMD, w);
        p = 32'h1;
        while (p[0] !== 1'b0) begin
            busRd(`COP_ADDR_CMD, p);
        end
        p = 32'h7;
        while (p[2:0] !== 3'h0) begin
            busRd(`COP_ADDR_STATUS, p);
        end
    endtask : cmd
    task automatic waitFill(input int n);
        r = '0;
        while (int'(r[12:8]) != n) begin
            busRd(`COP_ADDR_STATUS, r);
        end
    endtask : waitFill
    task automatic summarize;
        if (n_errors == 0 && samples_checked > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask : summarize

    // ****************************************
    // Test sequence
    // ****************************************
    initial begin
        rst = 1'b1;
        avsAddress = 4'h0;
        avsRead = 1'b0;
        avsWrite = 1'b0;
        avsWriteData = 32'h0;
        avsByteEnable = 4'hf;
        ackDelay = 8'h1e;
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        busRd(`COP_ADDR_CTRL, r);
        check(r, `COP_CTRL_RST);
        busRd(`COP_ADDR_CTXPF, r);
        check(r, 32'h0000_000f);
        busRd(4'h2, r);
        check(r, 32'h0);
        waitFill(8);
        check({27'h0, r[12:8]}, 32'h8);
        check({31'h0, pfActive}, 32'h1);
        cmd(32'h0);
        check(lineData[511:480], 32'h1);
        // Posted kinds, then non-posted ones that wait for every ack, then a posted non-stalling sync
        for (int i = 0; i < 13; i++) begin
            cmd(wTab[i]);
            check(reqN - r0, 32'h1);
            check({31'h0, lastPosted}, {31'h0, pTab[i]});
            check({31'h0, ackN == reqN}, {31'h0, !pTab[i]});
        end
        for (int i = 0; i < 3; i++) begin
            cmd(32'h4);
            check({31'h0, ackN == reqN}, 32'h0);
            cmd(dTab[i]);
            check({31'h0, ackN == reqN}, 32'h1);
        end
        for (int i = 0; i < 3; i++) begin
            cmd(32'h4);
            cmd(gTab[i]);
            check(gapAtReg, (gTab[i][3:0] == 4'he) ? 32'h1 : 32'h0);
            check({31'h0, rackN == rreqN}, {31'h0, gEq[i]});
        end
        cmd(32'h4);
        cmd(32'h8);
        check(gapAtMem, 32'h0);
        busWr(`COP_ADDR_CTRL, 32'h0000_0800);
        @(posedge clk);
        check({31'h0, pfActive}, 32'h0);
        busWr(`COP_ADDR_CTRL, `COP_CTRL_RST);
        cmd(32'h0000_f);
        check({31'h0, pfActive}, 32'h0);
        busRd(`COP_ADDR_CTXPF, r);
        check(r, 32'h0000_000e);
        cmd(32'h0002_000f);
        cmd(32'h0000_100f);
        busRd(`COP_ADDR_CTXPF, r);
        check(r, 32'h0000_000b);
        check({31'h0, pfActive}, 32'h1);
        cmd(32'h0002_100f);
        cmd(32'h0000_100f);
        // Depth request above the storage is clamped
        busWr(`COP_ADDR_CTRL, 32'h0000_1401);
        waitFill(16);
        check({27'h0, r[12:8]}, 32'h10);
        repeat (40) @(posedge clk);
        check({31'h0, fetchReq}, 32'h0);
        check(ackN, reqN);
        check(rackN, rreqN);
        summarize();
    end
endmodule : cop_parser_test

// ===== cop_pkg.sv
// Types of the command ordering and prefetch block
package cop_pkg;
    typedef enum logic [3:0] {
        OP_NOP        = 4'h0,
        OP_STORE_REG  = 4'h1,
        OP_MEM_COPY   = 4'h2,
        OP_STORE_IDX  = 4'h3,
        OP_STORE_IMM  = 4'h4,
        OP_REPORT_HD  = 4'h5,
        OP_UPDATE_TT  = 4'h6,
        OP_PERF_REP   = 4'h7,
        OP_ATOMIC     = 4'h8,
        OP_FLUSH_DW   = 4'h9,
        OP_PIPE_SYNC  = 4'ha,
        OP_MATH_STI   = 4'hb,
        OP_MATH_FENCE = 4'hc,
        OP_LOAD_MEM   = 4'hd,
        OP_REG_WRITE  = 4'he,
        OP_ARB_CHECK  = 4'hf
    } cop_op_e;
    typedef enum logic [2:0] {
        ST_IDLE  = 3'b000,
        ST_ISSUE = 3'b001,
        ST_DRAIN = 3'b010,
        ST_WAITW = 3'b011,
        ST_WAITR = 3'b100
    } cop_state_e;
    typedef struct packed {
        logic       valid;
        logic       posted;
        logic       isReg;
    } cop_wreq_s;
    typedef logic [3:0] cop_cnt_t;
endpackage : cop_pkg
